//--- pkg/adcsq_regs.svh
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// ----------------------------------------
// Register offsets on the device port
// ----------------------------------------
`define ADCSQ_CTRL0_OFS 8'h00
`define ADCSQ_CTRL1_OFS 8'h01
`define ADCSQ_CTRL2_OFS 8'h02
`define ADCSQ_IRQ_OFS 8'h03
`define ADCSQ_RES_OFS 8'h08
`define ADCSQ_ANDIR_OFS 8'h10
`define ADCSQ_TRGDIR_OFS 8'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCSQ_C0_START_BIT 6
`define ADCSQ_C0_TSEL_BIT 7
`define ADCSQ_C1_REF_BIT 5
`define ADCSQ_C2_SH_BIT 7
`define ADCSQ_IRQ_FLAG_BIT 3
`define ADCSQ_IRQ_LVL_RST 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCSQ_SYS_PERIOD_NS 100
`define ADCSQ_SYS_CLK_KHZ 10000
`define ADCSQ_REF_SETTLE_NS 1000
`define ADCSQ_REF_SETTLE_CYC ((`ADCSQ_REF_SETTLE_NS + `ADCSQ_SYS_PERIOD_NS - 1) / `ADCSQ_SYS_PERIOD_NS)
`define ADCSQ_CCLK_MAX_KHZ 10000
`define ADCSQ_CCLK_MIN_KHZ 250
`define ADCSQ_CCLK_MIN_SH_KHZ 1000
`endif

//--- pkg/adcsq_pkg.sv
package adcsq_pkg;
  typedef enum logic [2:0] {
    ADCSQ_ONE_SHOT, ADCSQ_REPEAT, ADCSQ_SINGLE_SWEEP, ADCSQ_REP_SWEEP0, ADCSQ_REP_SWEEP1
  } adcsq_mode_t;

  typedef enum logic [2:0] {
    ADCSQ_OP_CONFIG, ADCSQ_OP_START, ADCSQ_OP_STOP, ADCSQ_OP_READ, ADCSQ_OP_TRIG
  } adcsq_op_t;

  typedef enum {
    S_IDLE, S_DIR_AN, S_DIR_TRG, S_WR_C0, S_WR_C1, S_WR_C2, S_WAIT, S_GO,
    S_POLL, S_CHK, S_ACK, S_RES, S_CAP, S_IRQ_OFF, S_HALT, S_RSP
  } adcsq_state_t;

  typedef struct packed {
    adcsq_state_t st;
    adcsq_op_t op;
    logic [7:0] dev_addr;
    logic [7:0] dev_wdata;
    logic dev_wr;
    logic dev_rd;
    logic trig;
    logic [2:0] ch;
    adcsq_mode_t mode;
    logic [1:0] sweep;
    logic tsel;
    logic sh;
    logic [5:0] div;
    logic ref_on;
    logic [2:0] irq_lvl;
    logic [2:0] rsel;
    logic [7:0] settle;
    logic running;
    logic stale;
    logic clk_full;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
  } adcsq_ctx_t;
endpackage : adcsq_pkg

//--- verilog/adcsq_host.sv
`timescale 1ns/100ps
`include "adcsq_regs.svh"

module adcsq_host
  import adcsq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // User command port
  input wire logic cmd_valid,
  input wire adcsq_op_t cmd_op,
  output logic cmd_ready,
  input wire logic [2:0] cfg_channel,
  input wire adcsq_mode_t cfg_mode,
  input wire logic [1:0] cfg_sweep,
  input wire logic cfg_trig_sel,
  input wire logic cfg_sample_hold,
  input wire logic [5:0] cfg_clk_div,
  input wire logic cfg_ref_connect,
  input wire logic [2:0] cfg_irq_level,
  input wire logic key_irq_en,
  input wire logic [2:0] rd_index,
  // User answers and status
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_data,
  output logic conv_running,
  output logic results_stale,
  output logic cpu_clk_undivided,
  // Device register port
  output logic [7:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [15:0] dev_rdata,
  // Trigger pin
  output logic ext_trigger_pin
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] used_mask(input logic sweep_mode, input logic [2:0] ch,
                                           input logic [1:0] sw);
    logic [7:0] m;
    m = 8'h00;
    if (sweep_mode) begin
      for (int i = 0; i < 8; i++) begin
        if (i < 2 * (int'(sw) + 1)) begin
          m[i] = 1'b1;
        end
      end
    end else begin
      m[ch] = 1'b1;
    end
    return m;
  endfunction : used_mask

  function automatic logic clk_ok(input logic [5:0] div, input logic sh);
    int n;
    n = int'(div);
    if (n == 0) begin
      return 1'b0;
    end
    if (n * `ADCSQ_CCLK_MAX_KHZ < `ADCSQ_SYS_CLK_KHZ) begin
      return 1'b0;
    end
    if (sh) begin
      return n * `ADCSQ_CCLK_MIN_SH_KHZ <= `ADCSQ_SYS_CLK_KHZ;
    end
    return n * `ADCSQ_CCLK_MIN_KHZ <= `ADCSQ_SYS_CLK_KHZ;
  endfunction : clk_ok

  function automatic logic is_sweep(input adcsq_mode_t m);
    return m != ADCSQ_ONE_SHOT && m != ADCSQ_REPEAT;
  endfunction : is_sweep

  function automatic logic is_single(input adcsq_mode_t m);
    return m == ADCSQ_ONE_SHOT || m == ADCSQ_SINGLE_SWEEP;
  endfunction : is_single

  // ----------------------------------------
  // State
  // ----------------------------------------
  adcsq_ctx_t ctx_r;
  adcsq_ctx_t ctx_nxt;
  logic [7:0] cfg_mask;
  logic cfg_bad;
  logic [7:0] ctrl0_val;

  assign cfg_mask = used_mask(is_sweep(cfg_mode), cfg_channel, cfg_sweep);
  assign cfg_bad = !clk_ok(cfg_clk_div, cfg_sample_hold) ||
                   (key_irq_en && cfg_mask[7:4] != 4'h0);
  assign ctrl0_val = {ctx_r.tsel, 1'b0, ctx_r.mode, ctx_r.ch};

  always_comb begin
    ctx_nxt = ctx_r;
    ctx_nxt.dev_wr = 1'b0;
    ctx_nxt.dev_rd = 1'b0;
    ctx_nxt.trig = 1'b0;
    ctx_nxt.rsp_valid = 1'b0;
    if (ctx_r.settle != 8'h00) begin
      ctx_nxt.settle = ctx_r.settle - 8'h01;
    end
    case (ctx_r.st)
      S_IDLE: begin
        if (cmd_valid) begin
          ctx_nxt.op = cmd_op;
          ctx_nxt.rsp_err = 1'b0;
          ctx_nxt.st = S_RSP;
          case (cmd_op)
            ADCSQ_OP_CONFIG: begin
              // Settings refused while converting: the device latches them live
              if (ctx_r.running || cfg_bad) begin
                ctx_nxt.rsp_err = 1'b1;
              end else begin
                ctx_nxt.ch = cfg_channel;
                ctx_nxt.mode = cfg_mode;
                ctx_nxt.sweep = cfg_sweep;
                ctx_nxt.tsel = cfg_trig_sel;
                ctx_nxt.sh = cfg_sample_hold;
                ctx_nxt.div = cfg_clk_div;
                ctx_nxt.ref_on = cfg_ref_connect;
                ctx_nxt.irq_lvl = cfg_irq_level;
                if (cfg_ref_connect && !ctx_r.ref_on) begin
                  // Counted from the take: two extra cycles reach the reference write
                  ctx_nxt.settle = 8'(`ADCSQ_REF_SETTLE_CYC + 2);
                end
                ctx_nxt.dev_addr = `ADCSQ_ANDIR_OFS;
                ctx_nxt.dev_wdata = ~cfg_mask;
                ctx_nxt.dev_wr = 1'b1;
                ctx_nxt.st = S_DIR_AN;
              end
            end
            ADCSQ_OP_START: begin
              if (ctx_r.running) begin
                ctx_nxt.rsp_err = 1'b1;
              end else begin
                ctx_nxt.clk_full = !is_single(ctx_r.mode);
                ctx_nxt.st = S_WAIT;
              end
            end
            ADCSQ_OP_STOP: begin
              if (ctx_r.mode == ADCSQ_SINGLE_SWEEP && ctx_r.running) begin
                ctx_nxt.dev_addr = `ADCSQ_IRQ_OFS;
                ctx_nxt.dev_wdata = {5'h00, `ADCSQ_IRQ_LVL_RST};
                ctx_nxt.dev_wr = 1'b1;
                ctx_nxt.st = S_IRQ_OFF;
              end else begin
                ctx_nxt.st = S_IRQ_OFF;
              end
            end
            ADCSQ_OP_READ: begin
              ctx_nxt.rsel = rd_index;
              if (ctx_r.stale) begin
                ctx_nxt.rsp_err = 1'b1;
              end else if (is_single(ctx_r.mode) && ctx_r.running) begin
                ctx_nxt.st = S_POLL;
              end else begin
                ctx_nxt.st = S_RES;
              end
            end
            default: begin
              ctx_nxt.trig = ctx_r.tsel;
              ctx_nxt.rsp_err = !ctx_r.tsel || !ctx_r.running;
            end
          endcase
        end
      end
      S_DIR_AN: begin
        ctx_nxt.dev_addr = `ADCSQ_TRGDIR_OFS;
        ctx_nxt.dev_wdata = 8'h00;
        ctx_nxt.dev_wr = ctx_r.tsel;
        ctx_nxt.st = S_DIR_TRG;
      end
      S_DIR_TRG: begin
        // Channel and sweep both rewritten every time, mode change or not
        ctx_nxt.dev_addr = `ADCSQ_CTRL0_OFS;
        ctx_nxt.dev_wdata = ctrl0_val;
        ctx_nxt.dev_wr = 1'b1;
        ctx_nxt.st = S_WR_C0;
      end
      S_WR_C0: begin
        ctx_nxt.dev_addr = `ADCSQ_CTRL1_OFS;
        ctx_nxt.dev_wdata = {2'h0, ctx_r.ref_on, 3'h0, ctx_r.sweep};
        ctx_nxt.dev_wr = 1'b1;
        ctx_nxt.st = S_WR_C1;
      end
      S_WR_C1: begin
        ctx_nxt.dev_addr = `ADCSQ_CTRL2_OFS;
        ctx_nxt.dev_wdata = {ctx_r.sh, 1'b0, ctx_r.div};
        ctx_nxt.dev_wr = 1'b1;
        ctx_nxt.st = S_WR_C2;
      end
      S_WR_C2: begin
        ctx_nxt.dev_addr = `ADCSQ_IRQ_OFS;
        ctx_nxt.dev_wdata = {5'h00, ctx_r.irq_lvl};
        ctx_nxt.dev_wr = 1'b1;
        ctx_nxt.st = S_RSP;
      end
      S_WAIT: begin
        if (ctx_r.settle == 8'h00) begin
          ctx_nxt.dev_addr = `ADCSQ_CTRL0_OFS;
          ctx_nxt.dev_wdata = ctrl0_val;
          ctx_nxt.dev_wdata[`ADCSQ_C0_START_BIT] = 1'b1;
          ctx_nxt.dev_wr = 1'b1;
          ctx_nxt.st = S_GO;
        end
      end
      S_GO: begin
        ctx_nxt.running = 1'b1;
        ctx_nxt.stale = 1'b0;
        ctx_nxt.st = S_RSP;
      end
      S_POLL: begin
        ctx_nxt.dev_addr = `ADCSQ_IRQ_OFS;
        ctx_nxt.dev_rd = 1'b1;
        ctx_nxt.st = S_CHK;
      end
      S_CHK: begin
        // Result is safe to read only once the request flag is seen
        if (dev_rdata[`ADCSQ_IRQ_FLAG_BIT]) begin
          ctx_nxt.running = 1'b0;
          ctx_nxt.dev_addr = `ADCSQ_IRQ_OFS;
          ctx_nxt.dev_wdata = {5'h00, ctx_r.irq_lvl};
          ctx_nxt.dev_wr = 1'b1;
          ctx_nxt.st = S_ACK;
        end else begin
          ctx_nxt.st = S_POLL;
        end
      end
      S_ACK: begin
        ctx_nxt.st = S_RES;
      end
      S_RES: begin
        ctx_nxt.dev_addr = `ADCSQ_RES_OFS + {5'h00, ctx_r.rsel};
        ctx_nxt.dev_rd = 1'b1;
        ctx_nxt.st = S_CAP;
      end
      S_CAP: begin
        ctx_nxt.rsp_data = dev_rdata;
        ctx_nxt.st = S_RSP;
      end
      S_IRQ_OFF: begin
        ctx_nxt.dev_addr = `ADCSQ_CTRL0_OFS;
        ctx_nxt.dev_wdata = ctrl0_val;
        ctx_nxt.dev_wr = 1'b1;
        ctx_nxt.st = S_HALT;
      end
      S_HALT: begin
        if (ctx_r.running) begin
          ctx_nxt.stale = 1'b1;
        end
        ctx_nxt.running = 1'b0;
        ctx_nxt.clk_full = 1'b0;
        ctx_nxt.st = S_RSP;
      end
      default: begin
        ctx_nxt.rsp_valid = 1'b1;
        ctx_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctx_r <= '{st: S_IDLE, op: ADCSQ_OP_CONFIG, mode: ADCSQ_ONE_SHOT, default: '0};
    end else begin
      ctx_r <= ctx_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_ready = ctx_r.st == S_IDLE;
  assign rsp_valid = ctx_r.rsp_valid;
  assign rsp_err = ctx_r.rsp_err;
  assign rsp_data = ctx_r.rsp_data;
  assign conv_running = ctx_r.running;
  assign results_stale = ctx_r.stale;
  assign cpu_clk_undivided = ctx_r.clk_full;
  assign dev_addr = ctx_r.dev_addr;
  assign dev_wdata = ctx_r.dev_wdata;
  assign dev_wr = ctx_r.dev_wr;
  assign dev_rd = ctx_r.dev_rd;
  assign ext_trigger_pin = ctx_r.trig;

endmodule : adcsq_host

//--- testbench/adcsq_host_props.sv
`timescale 1ns/100ps
module adcsq_host_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic key_irq_en,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic conv_running,
  input wire logic cpu_clk_undivided,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic [15:0] dev_rdata
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic ref_r, polled_r, irq_off_r;
  logic [3:0] settle_r;
  wire c0_wr = dev_wr && dev_addr == 8'h00;
  wire c1_wr = dev_wr && dev_addr == 8'h01;
  wire c2_wr = dev_wr && dev_addr == 8'h02;
  wire res_rd = dev_rd && dev_addr[7:3] == 5'h01;
  wire irq_rd = dev_rd && dev_addr == 8'h03;
  wire c0_start = c0_wr && dev_wdata[6];
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_r <= 1'b0;
      polled_r <= 1'b0;
      irq_off_r <= 1'b0;
      settle_r <= 4'hF;
    end else begin
      if (c1_wr) ref_r <= dev_wdata[5];
      // Saturates so a long idle never wraps back under the limit
      if (c1_wr && dev_wdata[5] && !ref_r) settle_r <= 4'h0;
      else if (settle_r != 4'hF) settle_r <= settle_r + 4'h1;
      // Flag answer stands in the same cycle as its read strobe
      if (irq_rd && dev_rdata[3]) polled_r <= 1'b1;
      else if (c0_start) polled_r <= 1'b0;
      if (dev_wr && dev_addr == 8'h03 && dev_wdata[2:0] == 3'h0) irq_off_r <= 1'b1;
      else if (c0_start) irq_off_r <= 1'b0;
    end
  end
  ctrl_quiet_a: assert property ((c1_wr || c2_wr) |-> !conv_running)
    else $error("control write while running");
  ref_settle_a: assert property (c0_start && ref_r |-> settle_r >= 4'h9)
    else $error("start too soon after reference connect");
  trig_input_a: assert property (dev_wr && dev_addr == 8'h11 |-> !dev_wdata[0])
    else $error("trigger pin not input");
  key_chan_a: assert property (dev_wr && dev_addr == 8'h10 && key_irq_en |->
    dev_wdata[7:4] == 4'hF)
    else $error("upper channel used with key input");
  clk_max_a: assert property (c2_wr |-> dev_wdata[5:0] != 6'h00)
    else $error("conversion clock too fast");
  clk_min_a: assert property (c2_wr |-> dev_wdata[5:0] <= (dev_wdata[7] ? 6'h0A : 6'h28))
    else $error("conversion clock too slow");
  reselect_a: assert property (c2_wr |-> $past(c1_wr) && $past(c0_wr, 2))
    else $error("channel and sweep not rewritten");
  flag_first_a: assert property (res_rd && !cpu_clk_undivided |-> polled_r)
    else $error("result read before completion flag");
  full_clk_a: assert property (c0_start && dev_wdata[5:3] inside {3'h1, 3'h3, 3'h4}
    |-> ##[1:4] cpu_clk_undivided)
    else $error("repeat mode without undivided clock");
  irq_off_a: assert property (c0_wr && !dev_wdata[6] && conv_running &&
    dev_wdata[5:3] == 3'h2 |-> irq_off_r)
    else $error("sweep abort with interrupt enabled");
  cover property (c0_wr && dev_wdata[6]);
  cover property (rsp_valid && rsp_err);
  cover property (dev_wr && dev_addr == 8'h11);
endmodule : adcsq_host_props

//--- testbench/adcsq_dev_model.sv
`timescale 1ns/100ps
module adcsq_dev_model #(
  parameter int CONV_CYC = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port and pins
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [15:0] dev_rdata,
  input wire logic ext_trigger_pin,
  input wire logic cpu_clk_undivided
);
  logic [7:0] ctrl0_r, ctrl1_r, irq_r;
  logic [15:0] res_r [8];
  logic [15:0] idle_r;
  int cnt_r;
  // Read answer stands in the strobe cycle, as the host samples it there
  assign dev_rdata = !dev_rd ? idle_r : dev_addr[3] ? res_r[dev_addr[2:0]] : {8'h00, irq_r};
  function automatic logic hit(input int i);
    if (ctrl0_r[5:3] < 3'h2) return i == int'(ctrl0_r[2:0]);
    return i < 2 * int'(ctrl1_r[1:0]) + 2;
  endfunction : hit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_r <= 8'h00;
      ctrl1_r <= 8'h00;
      irq_r <= 8'h00;
      cnt_r <= 0;
      idle_r <= 16'h0000;
      for (int i = 0; i < 8; i++) res_r[i] <= 16'h0000;
    end else begin
      // Idle data toggles so a late sample never matches
      idle_r <= ~idle_r;
      if (ctrl0_r[7] && ctrl0_r[6] && ext_trigger_pin && cnt_r == 0) cnt_r <= CONV_CYC;
      if (cnt_r > 1) cnt_r <= cnt_r - 1;
      if (cnt_r == 1) begin
        for (int i = 0; i < 8; i++) begin
          if (hit(i)) res_r[i] <= (dev_rd && dev_addr == 8'(8 + i) && !cpu_clk_undivided) ?
            16'hBAD0 : 16'h5A00 + 16'(i);
        end
        irq_r[3] <= 1'b1;
        if (ctrl0_r[5:3] == 3'h0 || ctrl0_r[5:3] == 3'h2) ctrl0_r[6] <= 1'b0;
        else cnt_r <= CONV_CYC;
      end
      if (dev_wr && dev_addr == 8'h00) begin
        if (ctrl0_r[6] && !dev_wdata[6]) begin
          for (int i = 0; i < 8; i++) res_r[i] <= ~res_r[i];
        end
        ctrl0_r <= dev_wdata;
        cnt_r <= (dev_wdata[6] && !dev_wdata[7]) ? CONV_CYC : 0;
      end
      if (dev_wr && dev_addr == 8'h01) ctrl1_r <= dev_wdata;
      if (dev_wr && dev_addr == 8'h03) irq_r <= dev_wdata;
    end
  end
endmodule : adcsq_dev_model

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import adcsq_pkg::*;
  logic sys_clk, rst_b, cmd_valid, cmd_ready, cfg_trig_sel, cfg_sample_hold, cfg_ref_connect;
  logic key_irq_en, rsp_valid, rsp_err, conv_running, results_stale, cpu_clk_undivided;
  logic dev_wr, dev_rd, ext_trigger_pin, rep;
  logic [2:0] cfg_channel, cfg_irq_level, rd_index;
  logic [1:0] cfg_sweep;
  logic [5:0] cfg_clk_div;
  logic [7:0] dev_addr, dev_wdata;
  logic [15:0] rsp_data, dev_rdata;
  logic [6:0] tv [5] = '{7'h00, 7'h29, 7'h28, 7'h4B, 7'h4A};
  adcsq_op_t cmd_op;
  adcsq_mode_t cfg_mode;
  int err_count, cmp_count, cyc, seed_v, m, idx;
  adcsq_host adcsq_host_inst (.sys_clk, .rst_b, .cmd_valid, .cmd_op, .cmd_ready, .cfg_channel,
    .cfg_mode, .cfg_sweep, .cfg_trig_sel, .cfg_sample_hold, .cfg_clk_div, .cfg_ref_connect,
    .cfg_irq_level, .key_irq_en, .rd_index, .rsp_valid, .rsp_err, .rsp_data, .conv_running,
    .results_stale, .cpu_clk_undivided, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
    .ext_trigger_pin);
  adcsq_dev_model #(.CONV_CYC(20)) adcsq_dev_model_inst (.sys_clk, .rst_b, .dev_addr,
    .dev_wdata, .dev_wr, .dev_rd, .dev_rdata, .ext_trigger_pin, .cpu_clk_undivided);
  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic do_cmd(input adcsq_op_t op, input logic e);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 300);
    chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
    chk("rsp_err", {15'h0, e}, {15'h0, rsp_err});
  endtask : do_cmd
  task automatic cfg_set(input int md, input logic [2:0] ch, input logic [1:0] sw,
      input logic ts, input logic [6:0] sd, input logic key);
    @(posedge sys_clk);
    cfg_mode <= adcsq_mode_t'(md[2:0]);
    cfg_channel <= ch;
    cfg_sweep <= sw;
    cfg_trig_sel <= ts;
    cfg_sample_hold <= sd[6];
    cfg_clk_div <= sd[5:0];
    key_irq_en <= key;
    cfg_ref_connect <= 1'($urandom);
    cfg_irq_level <= 3'($urandom);
  endtask : cfg_set
  function automatic logic bad_clk(input logic [6:0] sd);
    return sd[5:0] == 6'h00 || sd[5:0] > (sd[6] ? 6'h0A : 6'h28);
  endfunction : bad_clk
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {rst_b, cmd_valid, cfg_trig_sel, cfg_sample_hold, cfg_ref_connect, key_irq_en} = '0;
    {cfg_channel, cfg_irq_level, rd_index, cfg_sweep, cfg_clk_div} = '0;
    cmd_op = ADCSQ_OP_CONFIG;
    cfg_mode = ADCSQ_ONE_SHOT;
    seed_v = $urandom(32'h06239cd6);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("cmd_ready", 16'h0001, {15'h0, cmd_ready});
    for (int k = 0; k < 5; k++) begin
      cfg_set(0, 3'h0, 2'h0, 1'b0, tv[k], 1'b0);
      do_cmd(ADCSQ_OP_CONFIG, bad_clk(tv[k]));
    end
    cfg_set(0, 3'h4, 2'h0, 1'b0, 7'h01, 1'b1);
    do_cmd(ADCSQ_OP_CONFIG, 1'b1);
    cfg_set(2, 3'h0, 2'h1, 1'b0, 7'h01, 1'b1);
    do_cmd(ADCSQ_OP_CONFIG, 1'b0);
    do_cmd(ADCSQ_OP_START, 1'b0);
    do_cmd(ADCSQ_OP_STOP, 1'b0);
    chk("results_stale", 16'h0001, {15'h0, results_stale});
    do_cmd(ADCSQ_OP_READ, 1'b1);
    for (int k = 0; k < 10; k++) begin
      m = (k < 5) ? k : $urandom_range(4);
      cfg_set(m, 3'($urandom), 2'($urandom), 1'($urandom),
        {1'($urandom), 6'($urandom_range(10, 1))}, 1'b0);
      do_cmd(ADCSQ_OP_CONFIG, 1'b0);
      do_cmd(ADCSQ_OP_START, 1'b0);
      do_cmd(ADCSQ_OP_START, 1'b1);
      do_cmd(ADCSQ_OP_TRIG, !cfg_trig_sel);
      rep = m inside {1, 3, 4};
      chk("cpu_clk_undivided", {15'h0, rep}, {15'h0, cpu_clk_undivided});
      idx = (m < 2) ? int'(cfg_channel) : $urandom_range(2 * int'(cfg_sweep) + 1);
      // Repeat modes read without polling, so let a pass land
      if (rep) repeat (60) @(negedge sys_clk);
      @(posedge sys_clk);
      rd_index <= idx[2:0];
      do_cmd(ADCSQ_OP_READ, 1'b0);
      chk("rsp_data", 16'h5A00 + 16'(idx), rsp_data);
      if (rep) begin
        do_cmd(ADCSQ_OP_CONFIG, 1'b1);
        do_cmd(ADCSQ_OP_STOP, 1'b0);
        chk("results_stale", 16'h0001, {15'h0, results_stale});
        do_cmd(ADCSQ_OP_READ, 1'b1);
      end
    end
    stop_test();
  end
endmodule : tb_top
bind adcsq_host adcsq_host_props adcsq_host_props_inst (.sys_clk, .rst_b, .key_irq_en,
  .rsp_valid, .rsp_err, .conv_running, .cpu_clk_undivided, .dev_addr, .dev_wdata, .dev_wr,
  .dev_rd, .dev_rdata);
